// file: rtl/bopd_pkg.sv
// Purpose: shared constants and types for the byte-op instruction decoder
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: opcode prefixes are the upper bits of the instruction word
package bopd_pkg;

	// ==========================================================
	// field positions
	localparam int BOPD_DEST_BIT = 9;
	localparam int BOPD_ACCESS_BIT = 8;
	localparam int BOPD_BITSEL_LSB = 9;
	localparam int BOPD_FADDR_W = 8;
	localparam int BOPD_FULL_ADDR_W = 12;
	localparam int BOPD_TARGET_W = 20;
	localparam int BOPD_LONG_OFS_W = 11;
	localparam int BOPD_SHORT_OFS_W = 8;
	localparam int BOPD_FAST_BIT = 8;
	localparam logic [3:0] BOPD_SECOND_WORD_TAG = 4'hf;

	// ==========================================================
	// reset values
	localparam logic [7:0] BOPD_ACCESS_BANK = 8'h00;
	localparam logic [3:0] BOPD_RESET_BANK = 4'h0;

	// ==========================================================
	// six-bit prefixes (bits 15..10) of d/a byte operations
	localparam logic [5:0] OP_ADD_WF = 6'h09;
	localparam logic [5:0] OP_ADD_WF_C = 6'h08;
	localparam logic [5:0] OP_AND_WF = 6'h05;
	localparam logic [5:0] OP_OR_WF = 6'h04;
	localparam logic [5:0] OP_XOR_WF = 6'h06;
	localparam logic [5:0] OP_COMP_F = 6'h07;
	localparam logic [5:0] OP_DEC_F = 6'h01;
	localparam logic [5:0] OP_INC_F = 6'h0a;
	localparam logic [5:0] OP_DEC_SZ = 6'h0b;
	localparam logic [5:0] OP_INC_SZ = 6'h0f;
	localparam logic [5:0] OP_DEC_SNZ = 6'h13;
	localparam logic [5:0] OP_INC_SNZ = 6'h12;
	localparam logic [5:0] OP_RL_C = 6'h0d;
	localparam logic [5:0] OP_RR_C = 6'h0c;
	localparam logic [5:0] OP_RL_N = 6'h11;
	localparam logic [5:0] OP_RR_N = 6'h10;
	localparam logic [5:0] OP_SWAP = 6'h0e;
	localparam logic [5:0] OP_SUB_WF = 6'h17;
	localparam logic [5:0] OP_SUB_WF_B = 6'h16;
	localparam logic [5:0] OP_SUB_FW_B = 6'h15;
	localparam logic [5:0] OP_MOVE_F = 6'h14;

	// seven-bit prefixes (bits 15..9) of a-only byte operations
	localparam logic [6:0] OP_CLR_F = 7'h35;
	localparam logic [6:0] OP_SET_F = 7'h34;
	localparam logic [6:0] OP_STORE_W = 7'h37;
	localparam logic [6:0] OP_NEG_F = 7'h36;
	localparam logic [6:0] OP_CMP_EQ = 7'h31;
	localparam logic [6:0] OP_CMP_GT = 7'h32;
	localparam logic [6:0] OP_CMP_LT = 7'h30;
	localparam logic [6:0] OP_TST_SZ = 7'h33;
	localparam logic [6:0] OP_MUL_WF = 7'h01;

	// four-bit prefixes, plus the five-bit branch, seven-bit call and eight-bit goto prefixes
	localparam logic [3:0] OP_MOVE_FF = 4'hc;
	localparam logic [3:0] OP_BIT_TOG = 4'h7;
	localparam logic [3:0] OP_BIT_SET = 4'h8;
	localparam logic [3:0] OP_BIT_CLR = 4'h9;
	localparam logic [3:0] OP_BIT_TSS = 4'ha;
	localparam logic [3:0] OP_BIT_TSC = 4'hb;
	localparam logic [4:0] OP_REL_BRANCH = 5'h1a;
	localparam logic [3:0] OP_COND_BRANCH = 4'he;
	localparam logic [7:0] OP_GOTO = 8'hef;
	localparam logic [6:0] OP_CALL = 7'h76;

	// flag update mask bit order: {n, ov, z, dc, c}
	localparam logic [4:0] FLAGS_ALL = 5'h1f;
	localparam logic [4:0] FLAGS_ZN = 5'h14;
	localparam logic [4:0] FLAGS_CZN = 5'h15;
	localparam logic [4:0] FLAGS_Z = 5'h04;
	localparam logic [4:0] FLAGS_NONE = 5'h00;

	typedef enum logic [4:0] {
		ALU_NOP, ALU_ADD, ALU_ADDC, ALU_AND, ALU_OR, ALU_XOR, ALU_COMP,
		ALU_CLR, ALU_SET, ALU_PASS_W, ALU_NEG, ALU_DEC, ALU_INC,
		ALU_RLC, ALU_RRC, ALU_RLN, ALU_RRN, ALU_SWAP, ALU_SUB, ALU_SUBB,
		ALU_RSUBB, ALU_MOVE, ALU_MUL, ALU_CMP, ALU_BIT
	} bopd_alu_e;

	typedef enum logic [2:0] {
		SKIP_NONE, SKIP_EQ, SKIP_GT, SKIP_LT, SKIP_ZERO, SKIP_NONZERO
	} bopd_skip_e;

endpackage

// file: rtl/bopd_field_split.sv
// Purpose: pull the operand fields out of one instruction word
// Assumes: word already registered in the core clock domain
// Notes: pure combinational; no state
`timescale 1ns/1ps
`default_nettype none
module bopd_field_split
	import bopd_pkg::*;
(
	input wire logic [15:0] word,
	output logic dest_file,
	output logic use_bank,
	output logic [7:0] file_addr,
	output logic [2:0] bit_pos,
	output logic [7:0] literal,
	output logic [11:0] long_addr,
	output logic [10:0] long_ofs,
	output logic [7:0] short_ofs,
	output logic fast,
	output logic second_word
);
	assign dest_file = word[BOPD_DEST_BIT];
	assign use_bank = word[BOPD_ACCESS_BIT];
	assign file_addr = word[BOPD_FADDR_W-1:0];
	assign bit_pos = word[BOPD_BITSEL_LSB+2:BOPD_BITSEL_LSB];
	assign literal = word[7:0];
	assign long_addr = word[BOPD_FULL_ADDR_W-1:0];
	assign long_ofs = word[BOPD_LONG_OFS_W-1:0];
	assign short_ofs = word[BOPD_SHORT_OFS_W-1:0];
	assign fast = word[BOPD_FAST_BIT];
	assign second_word = (word[15:12] == BOPD_SECOND_WORD_TAG);
endmodule
`default_nettype wire

// file: rtl/bopd_skip_eval.sv
// Purpose: decide whether a skip-type instruction skips
// Assumes: operands are unsigned bytes from the datapath
// Notes: compares are unsigned, as the core does
`timescale 1ns/1ps
`default_nettype none
module bopd_skip_eval
	import bopd_pkg::*;
(
	input wire bopd_skip_e kind,
	input wire logic [7:0] file_val,
	input wire logic [7:0] working_register_val,
	input wire logic [7:0] result_val,
	output logic take
);
	always_comb begin
		case (kind)
			SKIP_EQ: take = (file_val == working_register_val);
			SKIP_GT: take = (file_val > working_register_val);
			SKIP_LT: take = (file_val < working_register_val);
			SKIP_ZERO: take = (result_val == 8'h00);
			SKIP_NONZERO: take = (result_val != 8'h00);
			default: take = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: rtl/bopd_decoder.sv
// Purpose: decode 16-bit instruction words into datapath controls
// Assumes: one word per clock on fetch_word when fetch_valid is high
// Notes: controls reach the datapath one cycle after a word is taken; pins lag two cycles
// Operation
// - destination bit 0 writes working register, 1 writes the file register
// - access bit 0 uses fixed access bank, 1 uses bank select register
// - low 8 bits are the file address in byte and bit formats
// - file-to-file move is two words, 12-bit source then 1111 plus destination
// - bit operations select the bit with a 3-bit field above access bit
// - literal operand is the low 8 bits
// - jumps and calls build 20-bit target from low byte and second word
// - call first word carries the fast bit
// - long branch offset is 11 bits, conditional branch offset 8 bits
// - add and add-with-carry decode and update all five flags
// - and, or, xor, complement update only zero and negative
// - compare-skips and test-skip decode and leave flags alone
// - decrement/increment update flags; their skip forms do not
// - carry rotates update c,z,n; plain rotates z,n; swap none
// - three subtract forms update all five flags
// - file move updates z,n; multiply alters no flag
// - skip takes one cycle, two when taken, extra cycle a no-operation
// - stray second word executes as no-operation
// - read-modify-write on a port register reads the pins
// - writing timer zero clears its prescaler when assigned; a file-to-file move into it raises no prescaler_clear
// - fast bit 0 skips shadow transfer, 1 performs it
`timescale 1ns/1ps
`default_nettype none
module bopd_decoder
	import bopd_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_word,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] file_value,
	input wire logic [7:0] working_register,
	input wire logic [7:0] alu_result,
	input wire logic [7:0] pin_value,
	input wire logic port_is_io,
	input wire logic timer_zero_hit,
	input wire logic prescaler_on_timer,
	output logic [11:0] file_addr_out,
	output logic bit_pos_out,
	output logic [2:0] bit_sel,
	output logic [7:0] literal_out,
	output logic [7:0] operand_out,
	output bopd_alu_e alu_op,
	output logic [4:0] flag_update,
	output logic write_working_register,
	output logic write_file,
	output logic [11:0] move_src,
	output logic [11:0] move_dst,
	output logic move_write,
	output logic [19:0] jump_target,
	output logic jump_load,
	output logic call_push,
	output logic shadow_xfer,
	output logic [10:0] long_ofs_out,
	output logic [7:0] short_ofs_out,
	output logic skip_next,
	output logic prescaler_clear,
	output logic busy
);
	// ==========================================================
	// field extraction and state
	typedef enum logic [1:0] {BOPD_EXEC, BOPD_WAIT_MOVE, BOPD_WAIT_JUMP} bopd_state_e;

	bopd_state_e state_r;
	logic dest_file;
	logic use_bank;
	logic [7:0] faddr;
	logic [2:0] bpos;
	logic [7:0] lit;
	logic [11:0] laddr;
	logic [10:0] lofs;
	logic [7:0] sofs;
	logic fast;
	logic second_word;
	logic [11:0] move_src_r;
	logic [7:0] target_lo_r;
	logic is_call_r;
	logic fast_r;
	logic take_skip;
	bopd_skip_e skip_kind_r;
	logic skip_pending_r;

	bopd_field_split u_split (
		.word(fetch_word),
		.dest_file(dest_file),
		.use_bank(use_bank),
		.file_addr(faddr),
		.bit_pos(bpos),
		.literal(lit),
		.long_addr(laddr),
		.long_ofs(lofs),
		.short_ofs(sofs),
		.fast(fast),
		.second_word(second_word)
	);

	bopd_skip_eval u_skip (
		.kind(skip_kind_r),
		.file_val(file_value),
		.working_register_val(working_register),
		.result_val(alu_result),
		.take(take_skip)
	);

	function automatic logic [11:0] bank_addr(input logic ub, input logic [3:0] bank,
			input logic [7:0] a);
		bank_addr = ub ? {bank, a} : {BOPD_RESET_BANK, a};
	endfunction

	// ==========================================================
	// combinational decode of the word in execute state
	bopd_alu_e op_nxt;
	logic [4:0] flags_nxt;
	logic wr_w_nxt;
	logic wr_f_nxt;
	logic [11:0] addr_nxt;
	bopd_skip_e skip_nxt;
	logic lit_nxt;

	always_comb begin
		op_nxt = ALU_NOP;
		flags_nxt = FLAGS_NONE;
		wr_w_nxt = 1'b0;
		wr_f_nxt = 1'b0;
		skip_nxt = SKIP_NONE;
		lit_nxt = 1'b0;
		addr_nxt = bank_addr(use_bank, bank_select_register, faddr);
		case (fetch_word[15:10])
			OP_ADD_WF: begin op_nxt = ALU_ADD; flags_nxt = FLAGS_ALL; end
			OP_ADD_WF_C: begin op_nxt = ALU_ADDC; flags_nxt = FLAGS_ALL; end
			OP_AND_WF: begin op_nxt = ALU_AND; flags_nxt = FLAGS_ZN; end
			OP_OR_WF: begin op_nxt = ALU_OR; flags_nxt = FLAGS_ZN; end
			OP_XOR_WF: begin op_nxt = ALU_XOR; flags_nxt = FLAGS_ZN; end
			OP_COMP_F: begin op_nxt = ALU_COMP; flags_nxt = FLAGS_ZN; end
			OP_DEC_F: begin op_nxt = ALU_DEC; flags_nxt = FLAGS_ALL; end
			OP_INC_F: begin op_nxt = ALU_INC; flags_nxt = FLAGS_ALL; end
			OP_DEC_SZ: begin op_nxt = ALU_DEC; skip_nxt = SKIP_ZERO; end
			OP_INC_SZ: begin op_nxt = ALU_INC; skip_nxt = SKIP_ZERO; end
			OP_DEC_SNZ: begin op_nxt = ALU_DEC; skip_nxt = SKIP_NONZERO; end
			OP_INC_SNZ: begin op_nxt = ALU_INC; skip_nxt = SKIP_NONZERO; end
			OP_RL_C: begin op_nxt = ALU_RLC; flags_nxt = FLAGS_CZN; end
			OP_RR_C: begin op_nxt = ALU_RRC; flags_nxt = FLAGS_CZN; end
			OP_RL_N: begin op_nxt = ALU_RLN; flags_nxt = FLAGS_ZN; end
			OP_RR_N: begin op_nxt = ALU_RRN; flags_nxt = FLAGS_ZN; end
			OP_SWAP: op_nxt = ALU_SWAP;
			OP_SUB_WF: begin op_nxt = ALU_SUB; flags_nxt = FLAGS_ALL; end
			OP_SUB_WF_B: begin op_nxt = ALU_SUBB; flags_nxt = FLAGS_ALL; end
			OP_SUB_FW_B: begin op_nxt = ALU_RSUBB; flags_nxt = FLAGS_ALL; end
			OP_MOVE_F: begin op_nxt = ALU_MOVE; flags_nxt = FLAGS_ZN; end
			default: op_nxt = ALU_NOP;
		endcase
		if (op_nxt != ALU_NOP) begin
			wr_w_nxt = ~dest_file;
			wr_f_nxt = dest_file;
		end
		case (fetch_word[15:9])
			OP_CLR_F: begin op_nxt = ALU_CLR; flags_nxt = FLAGS_Z; wr_f_nxt = 1'b1; end
			OP_SET_F: begin op_nxt = ALU_SET; wr_f_nxt = 1'b1; end
			OP_STORE_W: begin op_nxt = ALU_PASS_W; wr_f_nxt = 1'b1; end
			OP_NEG_F: begin op_nxt = ALU_NEG; flags_nxt = FLAGS_ALL; wr_f_nxt = 1'b1; end
			OP_CMP_EQ: begin op_nxt = ALU_CMP; skip_nxt = SKIP_EQ; end
			OP_CMP_GT: begin op_nxt = ALU_CMP; skip_nxt = SKIP_GT; end
			OP_CMP_LT: begin op_nxt = ALU_CMP; skip_nxt = SKIP_LT; end
			OP_TST_SZ: begin op_nxt = ALU_MOVE; skip_nxt = SKIP_ZERO; end
			OP_MUL_WF: op_nxt = ALU_MUL;
			default: lit_nxt = 1'b0;
		endcase
		// bit-oriented group: write enable and skip decoded here, the bit work lies in the datapath
		if (fetch_word[15:12] >= OP_BIT_TOG && fetch_word[15:12] <= OP_BIT_TSC) begin
			op_nxt = ALU_BIT;
			wr_f_nxt = (fetch_word[15:12] <= OP_BIT_CLR);
			if (fetch_word[15:12] == OP_BIT_TSS || fetch_word[15:12] == OP_BIT_TSC) begin
				skip_nxt = SKIP_NONZERO;
			end
		end
		if (fetch_word[15:12] == 4'h0 && fetch_word[11:8] != 4'h0 && op_nxt == ALU_NOP) begin
			lit_nxt = 1'b1;
		end
	end

	// ==========================================================
	// sequencing of two-word and skip instructions
	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= BOPD_EXEC;
		end else if (fetch_valid) begin
			case (state_r)
				BOPD_EXEC: begin
					if (skip_pending_r && take_skip) begin
						// the squashed word is the no-operation cycle; the next word runs
						state_r <= BOPD_EXEC;
					end else if (fetch_word[15:12] == OP_MOVE_FF) begin
						state_r <= BOPD_WAIT_MOVE;
					end else if (fetch_word[15:8] == OP_GOTO || fetch_word[15:9] == OP_CALL) begin
						state_r <= BOPD_WAIT_JUMP;
					end
				end
				BOPD_WAIT_MOVE: state_r <= BOPD_EXEC;
				BOPD_WAIT_JUMP: state_r <= BOPD_EXEC;
				default: state_r <= BOPD_EXEC;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			move_src_r <= 12'h000;
			target_lo_r <= 8'h00;
			is_call_r <= 1'b0;
			fast_r <= 1'b0;
		end else if (fetch_valid && state_r == BOPD_EXEC) begin
			move_src_r <= laddr;
			target_lo_r <= lit;
			is_call_r <= (fetch_word[15:9] == OP_CALL);
			fast_r <= fast;
		end
	end

	// skip decision is made one cycle after the skip instruction issues
	always_ff @(posedge clock) begin
		if (reset) begin
			skip_pending_r <= 1'b0;
			skip_kind_r <= SKIP_NONE;
		end else if (fetch_valid) begin
			skip_pending_r <= (state_r == BOPD_EXEC) && (skip_nxt != SKIP_NONE)
				&& !(skip_pending_r && take_skip);
			skip_kind_r <= skip_nxt;
		end
	end

	// ==========================================================
	// registered controls to the datapath
	logic exec_now;
	assign exec_now = fetch_valid && state_r == BOPD_EXEC && !(skip_pending_r && take_skip);

	// pin levels come from outside the clock domain, so two flops before use;
	// a port read-modify-write therefore sees the pins as they stood two cycles back
	logic [7:0] pin_meta_r;
	logic [7:0] pin_sync_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			pin_meta_r <= 8'h00;
			pin_sync_r <= 8'h00;
		end else begin
			pin_meta_r <= pin_value;
			pin_sync_r <= pin_meta_r;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			alu_op <= ALU_NOP;
			flag_update <= FLAGS_NONE;
			write_working_register <= 1'b0;
			write_file <= 1'b0;
			file_addr_out <= 12'h000;
			bit_sel <= 3'h0;
			literal_out <= 8'h00;
			operand_out <= 8'h00;
			long_ofs_out <= 11'h000;
			short_ofs_out <= 8'h00;
			prescaler_clear <= 1'b0;
			bit_pos_out <= 1'b0;
		end else if (exec_now && !second_word) begin
			alu_op <= op_nxt;
			flag_update <= flags_nxt;
			write_working_register <= wr_w_nxt;
			write_file <= wr_f_nxt;
			file_addr_out <= addr_nxt;
			bit_sel <= bpos;
			bit_pos_out <= (op_nxt == ALU_BIT);
			literal_out <= lit_nxt ? lit : 8'h00;
			// pins stand in for the output latch on port read-modify-write
			operand_out <= port_is_io ? pin_sync_r : file_value;
			long_ofs_out <= lofs;
			short_ofs_out <= sofs;
			prescaler_clear <= wr_f_nxt && timer_zero_hit && prescaler_on_timer;
		end else begin
			// lone second word, squashed word and waits all issue a no-operation
			alu_op <= ALU_NOP;
			flag_update <= FLAGS_NONE;
			write_working_register <= 1'b0;
			write_file <= 1'b0;
			prescaler_clear <= 1'b0;
			bit_pos_out <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			move_src <= 12'h000;
			move_dst <= 12'h000;
			move_write <= 1'b0;
			jump_target <= 20'h00000;
			jump_load <= 1'b0;
			call_push <= 1'b0;
			shadow_xfer <= 1'b0;
		end else begin
			move_write <= fetch_valid && state_r == BOPD_WAIT_MOVE && second_word;
			jump_load <= fetch_valid && state_r == BOPD_WAIT_JUMP && second_word;
			call_push <= fetch_valid && state_r == BOPD_WAIT_JUMP && second_word && is_call_r;
			shadow_xfer <= fetch_valid && state_r == BOPD_WAIT_JUMP && second_word
				&& is_call_r && fast_r;
			if (fetch_valid && state_r == BOPD_WAIT_MOVE) begin
				move_src <= move_src_r;
				move_dst <= laddr;
			end
			if (fetch_valid && state_r == BOPD_WAIT_JUMP) begin
				jump_target <= {laddr, target_lo_r};
			end
		end
	end

	assign skip_next = skip_pending_r && take_skip;
	assign busy = (state_r != BOPD_EXEC);
endmodule
`default_nettype wire

// file: tb/bopd_decoder_assertions.sv
// Purpose: port-level checks on the decoder
// Assumes: one clock domain, synchronous reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module bopd_decoder_assertions
	import bopd_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_word,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] pin_value,
	input wire logic port_is_io,
	input wire logic [11:0] file_addr_out,
	input wire logic [7:0] operand_out,
	input wire bopd_alu_e alu_op,
	input wire logic [4:0] flag_update,
	input wire logic write_working_register,
	input wire logic write_file,
	input wire logic [11:0] move_src,
	input wire logic [11:0] move_dst,
	input wire logic move_write,
	input wire logic [19:0] jump_target,
	input wire logic jump_load,
	input wire logic call_push,
	input wire logic shadow_xfer,
	input wire logic [10:0] long_ofs_out,
	input wire logic skip_next,
	input wire logic busy
);
	// ==========================================================
	// helpers
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic take;
	// a word is a fresh instruction only when not squashed and not an operand
	assign take = fetch_valid && !busy && !skip_next;
	sequence s_second;
		fetch_valid && fetch_word[15:12] == 4'hf;
	endsequence
	// ==========================================================
	// checks
	a_add_decode: assert property (take && fetch_word[15:10] == OP_ADD_WF
		|=> alu_op == ALU_ADD && flag_update == FLAGS_ALL) else $error("add decode wrong");
	a_dest_select: assert property (take && fetch_word[15:10] == OP_INC_F
		|=> write_file == $past(fetch_word[9]) && write_working_register == !$past(fetch_word[9]))
		else $error("destination select wrong");
	a_bank_select: assert property (take && fetch_word[15:10] == OP_INC_F
		|=> file_addr_out == ($past(fetch_word[8]) ? {$past(bank_select_register),
		$past(fetch_word[7:0])} : {4'h0, $past(fetch_word[7:0])})) else $error("bank wrong");
	a_move_pair: assert property (take && fetch_word[15:12] == OP_MOVE_FF ##1 s_second
		|=> move_write && move_src == $past(fetch_word[11:0], 2)
		&& move_dst == $past(fetch_word[11:0])) else $error("move pair wrong");
	a_goto_target: assert property (take && fetch_word[15:8] == OP_GOTO ##1 s_second
		|=> jump_load && jump_target == {$past(fetch_word[11:0]), $past(fetch_word[7:0], 2)})
		else $error("jump target wrong");
	a_call_shadow: assert property (take && fetch_word[15:9] == OP_CALL ##1 s_second
		|=> call_push && shadow_xfer == $past(fetch_word[8], 2)) else $error("call wrong");
	a_stray_nop: assert property (take && fetch_word[15:12] == 4'hf
		|=> alu_op == ALU_NOP && !write_working_register && !write_file) else $error("stray word acted");
	a_squash_nop: assert property (fetch_valid && skip_next
		|=> alu_op == ALU_NOP && !write_working_register && !write_file) else $error("squash failed");
	a_pins_source: assert property (take && fetch_word[15:10] == OP_INC_F && port_is_io
		|=> operand_out == $past(pin_value, 3)) else $error("port operand wrong");
	a_branch_ofs: assert property (take && fetch_word[15:11] == OP_REL_BRANCH
		|=> long_ofs_out == $past(fetch_word[10:0])) else $error("branch offset wrong");
endmodule
bind bopd_decoder bopd_decoder_assertions u_chk (.clock(clock), .reset(reset),
	.fetch_valid(fetch_valid), .fetch_word(fetch_word),
	.bank_select_register(bank_select_register), .pin_value(pin_value),
	.port_is_io(port_is_io), .file_addr_out(file_addr_out), .operand_out(operand_out),
	.alu_op(alu_op), .flag_update(flag_update), .write_working_register(write_working_register),
	.write_file(write_file), .move_src(move_src), .move_dst(move_dst),
	.move_write(move_write), .jump_target(jump_target), .jump_load(jump_load),
	.call_push(call_push), .shadow_xfer(shadow_xfer), .long_ofs_out(long_ofs_out),
	.skip_next(skip_next), .busy(busy));
`default_nettype wire

// file: tb/bopd_prog_mem.sv
// Purpose: program memory model feeding instruction words
// Assumes: bench changes req and word at the falling edge
// Notes: no storage beyond the word on offer
`timescale 1ns/1ps
`default_nettype none
module bopd_prog_mem (
	input wire logic clock,
	input wire logic req,
	input wire logic [15:0] word,
	output logic fetch_valid,
	output logic [15:0] fetch_word
);
	// ==========================================================
	// idle bus toggles each cycle between the inverse of the last word and the word itself
	logic [15:0] last_r = 16'h5a5a;
	always @(posedge clock) begin
		last_r <= fetch_word;
	end
	assign fetch_valid = req;
	assign fetch_word = req ? word : ~last_r;
endmodule
`default_nettype wire

// file: tb/bopd_decoder_tb_top.sv
// Purpose: directed test of the decoder
// Assumes: controls answer one cycle after a word is taken
// Notes: no handshake waits; a watchdog cuts a hang
`timescale 1ns/1ps
`default_nettype none
module bopd_decoder_tb_top
	import bopd_pkg::*;
();
	logic clock = 1'b0, reset = 1'b1, req = 1'b0, port_is_io = 1'b0;
	logic timer_zero_hit = 1'b0, prescaler_on_timer = 1'b0, fetch_valid;
	logic [15:0] word = 16'h0000, fetch_word;
	logic [3:0] bank_select_register = 4'h0;
	logic [7:0] file_value = 8'h03, working_register = 8'h05, alu_result = 8'h01;
	logic [7:0] pin_value = 8'h00, literal_out, operand_out, short_ofs_out;
	logic [11:0] file_addr_out, move_src, move_dst;
	logic [2:0] bit_sel;
	logic [4:0] flag_update;
	logic [19:0] jump_target;
	logic [10:0] long_ofs_out;
	logic bit_pos_out, write_working_register, write_file, move_write, jump_load, call_push;
	logic shadow_xfer, skip_next, prescaler_clear, busy;
	bopd_alu_e alu_op;
	int num_errors = 0, comparisons = 0;
	// {prefix with d=1, flag mask, alu op}; 5'h1f means op not checked
	logic [16:0] tbl [30] = '{
		{OP_ADD_WF, 1'b1, FLAGS_ALL, ALU_ADD}, {OP_ADD_WF_C, 1'b1, FLAGS_ALL, ALU_ADDC},
		{OP_AND_WF, 1'b1, FLAGS_ZN, ALU_AND}, {OP_OR_WF, 1'b1, FLAGS_ZN, ALU_OR},
		{OP_XOR_WF, 1'b1, FLAGS_ZN, ALU_XOR}, {OP_COMP_F, 1'b1, FLAGS_ZN, ALU_COMP},
		{OP_DEC_F, 1'b1, FLAGS_ALL, ALU_DEC}, {OP_INC_F, 1'b1, FLAGS_ALL, ALU_INC},
		{OP_DEC_SZ, 1'b1, FLAGS_NONE, 5'h1f}, {OP_INC_SZ, 1'b1, FLAGS_NONE, 5'h1f},
		{OP_DEC_SNZ, 1'b1, FLAGS_NONE, 5'h1f}, {OP_INC_SNZ, 1'b1, FLAGS_NONE, 5'h1f},
		{OP_RL_C, 1'b1, FLAGS_CZN, ALU_RLC}, {OP_RR_C, 1'b1, FLAGS_CZN, ALU_RRC},
		{OP_RL_N, 1'b1, FLAGS_ZN, ALU_RLN}, {OP_RR_N, 1'b1, FLAGS_ZN, ALU_RRN},
		{OP_SWAP, 1'b1, FLAGS_NONE, ALU_SWAP}, {OP_SUB_WF, 1'b1, FLAGS_ALL, ALU_SUB},
		{OP_SUB_WF_B, 1'b1, FLAGS_ALL, ALU_SUBB}, {OP_SUB_FW_B, 1'b1, FLAGS_ALL, ALU_RSUBB},
		{OP_MOVE_F, 1'b1, FLAGS_ZN, ALU_MOVE}, {OP_CLR_F, FLAGS_Z, ALU_CLR},
		{OP_SET_F, FLAGS_NONE, ALU_SET}, {OP_STORE_W, FLAGS_NONE, ALU_PASS_W},
		{OP_NEG_F, FLAGS_ALL, ALU_NEG}, {OP_CMP_EQ, FLAGS_NONE, 5'h1f},
		{OP_CMP_GT, FLAGS_NONE, 5'h1f}, {OP_CMP_LT, FLAGS_NONE, 5'h1f},
		{OP_TST_SZ, FLAGS_NONE, 5'h1f}, {OP_MUL_WF, FLAGS_NONE, ALU_MUL}};
	always #20 clock = ~clock;
	bopd_prog_mem u_mem (.clock(clock), .req(req), .word(word), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word));
	bopd_decoder uut (.clock(clock), .reset(reset), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .bank_select_register(bank_select_register),
		.file_value(file_value), .working_register(working_register),
		.alu_result(alu_result), .pin_value(pin_value), .port_is_io(port_is_io),
		.timer_zero_hit(timer_zero_hit), .prescaler_on_timer(prescaler_on_timer),
		.file_addr_out(file_addr_out), .bit_pos_out(bit_pos_out), .bit_sel(bit_sel),
		.literal_out(literal_out), .operand_out(operand_out), .alu_op(alu_op),
		.flag_update(flag_update), .write_working_register(write_working_register), .write_file(write_file),
		.move_src(move_src), .move_dst(move_dst), .move_write(move_write),
		.jump_target(jump_target), .jump_load(jump_load), .call_push(call_push),
		.shadow_xfer(shadow_xfer), .long_ofs_out(long_ofs_out),
		.short_ofs_out(short_ofs_out), .skip_next(skip_next),
		.prescaler_clear(prescaler_clear), .busy(busy));
	// ==========================================================
	// tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic send(input logic [15:0] w);
		@(negedge clock);
		req = 1'b1;
		word = w;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clock);
			req = 1'b0;
		end
	endtask
	// the answer of the last word stands during the cycle after it is taken
	task automatic op(input logic [15:0] w);
		send(w);
		idle(1);
	endtask
	task automatic end_sim;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// sequence
	initial begin
		repeat (2000) @(posedge clock);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		for (int i = 0; i < 30; i++) begin
			op({tbl[i][16:10], 1'b1, 8'h40});
			check("flag_update", flag_update, tbl[i][9:5]);
			if (tbl[i][4:0] != 5'h1f) begin
				check("alu_op", alu_op, tbl[i][4:0]);
			end
			// a filler word soaks up any skip this entry sets up
			op(16'h0000);
		end
		bank_select_register = 4'ha;
		pin_value = 8'h96;
		file_value = 8'h69;
		for (int d = 0; d < 2; d++) begin
			port_is_io = d[0];
			op({OP_INC_F, d[0], d[0], 8'h5c});
			check("write_file", write_file, d[0]);
			check("write_working_register", write_working_register, !d[0]);
			check("file_addr_out", file_addr_out, d[0] ? 12'ha5c : 12'h05c);
			check("operand_out", operand_out, d[0] ? 8'h96 : 8'h69);
			timer_zero_hit = 1'b1;
			prescaler_on_timer = d[0];
			op({OP_CLR_F, 1'b0, 8'h56});
			check("prescaler_clear", prescaler_clear, d[0]);
			timer_zero_hit = 1'b0;
		end
		port_is_io = 1'b0;
		file_value = 8'h03;
		send(16'hc123);
		send(16'hf456);
		check("busy", busy, 1'b1);
		idle(1);
		check("move_write", move_write, 1'b1);
		check("move_addrs", {move_src, move_dst}, 24'h123456);
		send({OP_GOTO, 8'h34});
		op(16'hfabc);
		check("goto", {jump_load, jump_target}, 21'h1abc34);
		for (int s = 0; s < 2; s++) begin
			send({OP_CALL, s[0], 8'h12});
			op(16'hf345);
			check("call", {call_push, shadow_xfer, jump_target}, {1'b1, s[0], 20'h34512});
		end
		send({OP_ADD_WF, 2'h3, 8'h22});
		op(16'hf777);
		check("stray", {alu_op, write_working_register, write_file}, {ALU_NOP, 2'h0});
		send({OP_ADD_WF, 2'h3, 8'h22});
		op(16'h0001);
		check("undefined", {alu_op, write_working_register, write_file}, {ALU_NOP, 2'h0});
		op(16'h0b5a);
		check("literal_out", literal_out, 8'h5a);
		op({OP_REL_BRANCH, 11'h5a5});
		check("long_ofs_out", long_ofs_out, 11'h5a5);
		op({OP_COND_BRANCH, 4'h2, 8'h9c});
		check("short_ofs_out", short_ofs_out, 8'h9c);
		op({OP_BIT_SET, 3'h5, 1'b0, 8'h21});
		check("bit", {bit_pos_out, bit_sel, file_addr_out}, 16'hd021);
		for (int e = 0; e < 2; e++) begin
			working_register = e[0] ? 8'h03 : 8'h04;
			send({OP_CMP_EQ, 1'b0, 8'h10});
			send({OP_ADD_WF, 2'h0, 8'h11});
			check("skip_next", skip_next, e[0]);
			send({OP_INC_F, 2'h0, 8'h11});
			check("after_skip", alu_op, e[0] ? ALU_NOP : ALU_ADD);
			idle(1);
			check("resume", alu_op, ALU_INC);
			idle(2);
		end
		end_sim();
	end
endmodule
`default_nettype wire
